//--- rtl/port_pin_override_mux.sv
`default_nettype none
// Behaviour
// - pull-up override enable selects override value only
// - otherwise pull-up on for pattern 010
// - direction override enable selects driver from value
// - otherwise driver enable follows direction bit
// - value override drives override value when driving
// - otherwise driven level equals output latch
// - toggle override inverts stored output latch
// - input-enable override value gates input buffer
// - otherwise input enabled unless sleep clamps
// - alternate input tapped before port synchronizer
// - reference pin: pull-up and driver forced off
// - port bit n feeds pin change source n
// - bit 2 feeds irq one and serial clock
// - bit 4 feeds timer0 capture input
// - direction bit one output, zero input
// - writing one to input bit toggles latch
// - sleep clamps non-overridden inputs to ground
module port_pin_override_mux (
  // clock and reset
  input  wire logic                                clk,
  input  wire logic                                rst_n,
  // avalon-mm slave
  input  wire logic [port_mux_pkg::ADDR_W-1:0]     avs_address,
  input  wire logic                                avs_read,
  input  wire logic                                avs_write,
  input  wire logic [port_mux_pkg::DATA_W-1:0]     avs_writedata,
  input  wire logic [3:0]                          avs_byteenable,
  output logic      [port_mux_pkg::DATA_W-1:0]     avs_readdata,
  output logic                                     avs_waitrequest,
  // overrides from alternate-function modules
  input  wire logic [port_mux_pkg::PORT_W-1:0]     pullup_override_en,
  input  wire logic [port_mux_pkg::PORT_W-1:0]     pullup_override_val,
  input  wire logic [port_mux_pkg::PORT_W-1:0]     dir_override_en,
  input  wire logic [port_mux_pkg::PORT_W-1:0]     dir_override_val,
  input  wire logic [port_mux_pkg::PORT_W-1:0]     value_override_en,
  input  wire logic [port_mux_pkg::PORT_W-1:0]     value_override_val,
  input  wire logic [port_mux_pkg::PORT_W-1:0]     toggle_override_en,
  input  wire logic [port_mux_pkg::PORT_W-1:0]     input_enable_override_en,
  input  wire logic [port_mux_pkg::PORT_W-1:0]     input_enable_override_val,
  // system state
  input  wire logic                                sleep_clamp,
  input  wire logic                                ext_analog_reference,
  // pads
  input  wire logic [port_mux_pkg::PORT_W-1:0]     pad_in,
  output logic      [port_mux_pkg::PORT_W-1:0]     pad_out,
  output logic      [port_mux_pkg::PORT_W-1:0]     pad_oe_n,
  output logic      [port_mux_pkg::PORT_W-1:0]     pad_pullup_en,
  // alternate-function inputs
  output logic      [port_mux_pkg::PORT_W-1:0]     alt_raw_digital_in,
  output logic      [port_mux_pkg::PORT_W-1:0]     pin_change_src,
  output logic                                     ext_irq_one,
  output logic                                     serial_iface_clock,
  output logic                                     timer0_capture_in
);
  import port_mux_pkg::*;

  state_t s_q;
  state_t s_d;

  logic              req;
  logic              take;
  logic              lane0;
  logic [PORT_W-1:0] wbyte;
  logic [PORT_W-1:0] digital_in;

  ////////////////////////////////////////////////////////////////////////////
  // per-pin override muxes, all combinational
  for (genvar i = 0; i < PORT_W; i++) begin : g_pin
    logic ref_force;
    logic pu_sw;
    logic pu_sel;
    logic oe_sel;
    logic die;

    // only the reference pin can be seized by the converter
    assign ref_force = (i == REF_BIT) ? ext_analog_reference : 1'b0;

    assign pu_sw  = ({s_q.dir[i], s_q.latch[i], s_q.global_pullup_disable} == PULLUP_PATTERN);
    assign pu_sel = pullup_override_en[i] ? pullup_override_val[i] : pu_sw;
    assign pad_pullup_en[i] = pu_sel & ~ref_force;

    // direction bit one drives, zero leaves the pad as input
    assign oe_sel = dir_override_en[i] ? dir_override_val[i] : s_q.dir[i];
    assign pad_oe_n[i] = ~(oe_sel & ~ref_force);

    assign pad_out[i] = value_override_en[i] ? value_override_val[i] : s_q.latch[i];

    // clamp to ground while asleep keeps floating pads from burning current
    assign die = input_enable_override_en[i] ? input_enable_override_val[i] : ~sleep_clamp;
    assign digital_in[i] = pad_in[i] & die;
  end

  ////////////////////////////////////////////////////////////////////////////
  // raw input to peripherals skips the synchronizer; they resync it
  assign alt_raw_digital_in = digital_in;
  assign pin_change_src     = digital_in;
  assign ext_irq_one        = digital_in[IRQ1_BIT];
  assign serial_iface_clock = digital_in[SCLK_BIT];
  assign timer0_capture_in  = digital_in[CAP_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // bus: one wait cycle, write and read data at the second edge
  assign req             = avs_read | avs_write;
  assign take            = req & s_q.ack;
  assign avs_waitrequest = req & ~s_q.ack;
  assign avs_readdata    = s_q.rdata;
  assign lane0           = avs_byteenable[0];
  assign wbyte           = avs_writedata[PORT_W-1:0];

  always_comb begin
    logic [PORT_W-1:0] latch_base;
    logic [PORT_W-1:0] sw_toggle;
    latch_base = s_q.latch;
    sw_toggle  = '0;
    s_d        = s_q;

    // first stage feeds only the second
    s_d.sync1 = digital_in;
    s_d.sync2 = s_q.sync1;

    s_d.ack = req & ~s_q.ack;

    if (req && !s_q.ack && avs_read) begin
      case (avs_address)
        DIR_OFS:   s_d.rdata = {24'h00_0000, s_q.dir};
        LATCH_OFS: s_d.rdata = {24'h00_0000, s_q.latch};
        PIN_OFS:   s_d.rdata = {24'h00_0000, s_q.sync2};
        CTRL_OFS:  s_d.rdata = {31'h0000_0000, s_q.global_pullup_disable};
        default:   s_d.rdata = RDATA_RST;
      endcase
    end

    if (take && avs_write && lane0) begin
      case (avs_address)
        DIR_OFS:   s_d.dir   = wbyte;
        LATCH_OFS: latch_base = wbyte;
        PIN_OFS:   sw_toggle  = wbyte;
        CTRL_OFS:  s_d.global_pullup_disable   = avs_writedata[CTRL_PUD_BIT];
        default:   s_d.global_pullup_disable   = s_q.global_pullup_disable;
      endcase
    end

    // both toggles stack on whatever software wrote this cycle
    s_d.latch = latch_base ^ sw_toggle ^ toggle_override_en;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q.dir   <= DIR_RST;
      s_q.latch <= LATCH_RST;
      s_q.global_pullup_disable   <= PUD_RST;
      s_q.sync1 <= SYNC_RST;
      s_q.sync2 <= SYNC_RST;
      s_q.ack   <= 1'b0;
      s_q.rdata <= RDATA_RST;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : port_pin_override_mux
`default_nettype wire

//--- rtl/port_mux_pkg.sv
`default_nettype none
package port_mux_pkg;

  localparam int unsigned PORT_W   = 8;
  localparam int unsigned ADDR_W   = 4;
  localparam int unsigned DATA_W   = 32;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [ADDR_W-1:0] DIR_OFS   = 4'h0;
  localparam logic [ADDR_W-1:0] LATCH_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] PIN_OFS   = 4'h8;
  localparam logic [ADDR_W-1:0] CTRL_OFS  = 4'hC;

  // control register field
  localparam int unsigned CTRL_PUD_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic [PORT_W-1:0] DIR_RST   = 8'h00;
  localparam logic [PORT_W-1:0] LATCH_RST = 8'h00;
  localparam logic              PUD_RST   = 1'b0;
  localparam logic [PORT_W-1:0] SYNC_RST  = 8'h00;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // pins with fixed alternate functions
  localparam int unsigned REF_BIT  = 3;
  localparam int unsigned IRQ1_BIT = 2;
  localparam int unsigned SCLK_BIT = 2;
  localparam int unsigned CAP_BIT  = 4;

  // pull-up on only for {dir, latch, pud} equal to this pattern
  localparam logic [2:0] PULLUP_PATTERN = 3'b010;

  typedef struct packed {
    logic [PORT_W-1:0] dir;
    logic [PORT_W-1:0] latch;
    logic              global_pullup_disable;
    logic [PORT_W-1:0] sync1;
    logic [PORT_W-1:0] sync2;
    logic              ack;
    logic [DATA_W-1:0] rdata;
  } state_t;

endpackage : port_mux_pkg
`default_nettype wire

//--- tb/port_mux_asserts.sv
`default_nettype none
module port_mux_asserts (
  // clock, reset and bus write
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       avs_write,
  // overrides and state
  input wire logic [7:0] pullup_override_en,
  input wire logic [7:0] pullup_override_val,
  input wire logic [7:0] dir_override_en,
  input wire logic [7:0] dir_override_val,
  input wire logic [7:0] value_override_en,
  input wire logic [7:0] value_override_val,
  input wire logic [7:0] toggle_override_en,
  input wire logic [7:0] input_enable_override_en,
  input wire logic [7:0] input_enable_override_val,
  input wire logic       sleep_clamp,
  input wire logic       ext_analog_reference,
  // pads and alternate inputs
  input wire logic [7:0] pad_in,
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe_n,
  input wire logic [7:0] pad_pullup_en,
  input wire logic [7:0] alt_raw_digital_in,
  input wire logic [7:0] pin_change_src,
  input wire logic       ext_irq_one,
  input wire logic       serial_iface_clock,
  input wire logic       timer0_capture_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ref_mask;
  // bit 3 masked only while the reference force wins
  assign ref_mask = {4'hF, ~ext_analog_reference, 3'h7};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  pullup_ovr_a: assert property (
    ((pad_pullup_en ^ pullup_override_val) & pullup_override_en & ref_mask) == 8'h00)
    else $error("pull-up override ignored");
  dir_ovr_a: assert property (
    ((~pad_oe_n ^ dir_override_val) & dir_override_en & ref_mask) == 8'h00)
    else $error("direction override ignored");
  value_ovr_a: assert property (
    ((pad_out ^ value_override_val) & value_override_en & ~pad_oe_n) == 8'h00)
    else $error("value override ignored");
  toggle_latch_a: assert property (
    (value_override_en == 8'h00 && !avs_write) ##1 (value_override_en == 8'h00)
    |-> pad_out == ($past(pad_out) ^ $past(toggle_override_en))) else $error("toggle override wrong");
  ref_force_a: assert property (
    ext_analog_reference |-> pad_oe_n[3] && !pad_pullup_en[3])
    else $error("reference pin not released");
  raw_input_a: assert property (
    alt_raw_digital_in == (pad_in & ((input_enable_override_en & input_enable_override_val)
    | (~input_enable_override_en & {8{!sleep_clamp}})))) else $error("raw input wrong");
  change_src_a: assert property (
    pin_change_src == alt_raw_digital_in) else $error("pin change source wrong");
  irq_clock_a: assert property (
    ext_irq_one == alt_raw_digital_in[2] && serial_iface_clock == ext_irq_one)
    else $error("bit 2 routing wrong");
  capture_in_a: assert property (
    timer0_capture_in == alt_raw_digital_in[4]) else $error("capture input wrong");
  cover property (toggle_override_en != 8'h00);
  cover property (ext_analog_reference && dir_override_en[3]);
  cover property (sleep_clamp && input_enable_override_en != 8'h00);
endmodule : port_mux_asserts
`default_nettype wire

//--- tb/periph_model.sv
`default_nettype none
module periph_model (
  // system
  input wire logic       clk,
  input wire logic       rst_n,
  // bench request, mux side
  input wire logic [7:0] toggle_req,
  input wire logic [7:0] alt_raw_digital_in,
  output logic     [7:0] toggle_override_en,
  output logic     [7:0] alt_sync
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] req_q;
  logic [7:0] meta_q;
  // mux toggles every high cycle, so a held request gives one pulse only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {req_q, toggle_override_en, meta_q, alt_sync} <= 32'h0000_0000;
    end else begin
      req_q <= toggle_req;
      toggle_override_en <= toggle_req & ~req_q;
      meta_q <= alt_raw_digital_in;
      alt_sync <= meta_q;
    end
  end
endmodule : periph_model
`default_nettype wire

//--- tb/port_pin_override_mux_tb_top.sv
`default_nettype none
module port_pin_override_mux_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import port_mux_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, sleep_clamp = 1'b0, ext_analog_reference = 1'b0;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rd;
  logic [7:0] pullup_override_en = 8'h00, pullup_override_val = 8'h00, dir_override_en = 8'h00, pad_in = 8'h00;
  logic [7:0] dir_override_val = 8'h00, value_override_en = 8'h00, value_override_val = 8'h00, toggle_req = 8'h00;
  logic [7:0] input_enable_override_en = 8'h00, input_enable_override_val = 8'h00, toggle_override_en, alt_sync;
  logic [7:0] pad_out, pad_oe_n, pad_pullup_en, alt_raw_digital_in, pin_change_src;
  logic avs_waitrequest, ext_irq_one, serial_iface_clock, timer0_capture_in;
  int bad_count = 0, num_checks = 0, cyc = 0;
  port_pin_override_mux u_dut (.*);
  periph_model u_periph (.*);
  initial forever #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // edge first so back-to-back calls never drive twice in one step
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    {avs_address, avs_write, avs_read, avs_writedata} <= {a, w, !w, 24'h000000, d};
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    {avs_write, avs_read} <= 2'b00;
  endtask : bus
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      stop_test;
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, DIR_OFS, 8'h00);
    chk(rd, {24'h000000, DIR_RST});
    bus(1'b1, LATCH_OFS, 8'hF0);
    bus(1'b1, DIR_OFS, 8'h30);
    @(negedge clk);
    chk({pad_pullup_en, pad_oe_n, pad_out}, 32'h00C0_CFF0);
    bus(1'b1, PIN_OFS, 8'h03);
    bus(1'b1, CTRL_OFS, 8'h01);
    bus(1'b0, LATCH_OFS, 8'h00);
    chk(rd, 32'h0000_00F3);
    // comparator pins 7 and 6 stay inputs with pull-ups off
    chk({pad_pullup_en, pad_out}, 32'h0000_00F3);
    bus(1'b0, 4'h2, 8'h00);
    chk(rd, 32'h0000_0000);
    // low lane disabled: the write must not land
    avs_byteenable <= 4'hE;
    bus(1'b1, DIR_OFS, 8'hFF);
    avs_byteenable <= 4'hF;
    bus(1'b0, DIR_OFS, 8'h00);
    chk(rd, 32'h0000_0030);
    @(posedge clk);
    {pullup_override_en, pullup_override_val, dir_override_en, dir_override_val} <= 32'h8101_FF0F;
    {value_override_en, value_override_val} <= 16'h0F05;
    @(negedge clk);
    chk({pad_pullup_en, pad_oe_n, pad_out}, 32'h0001_F0F5);
    @(posedge clk);
    {pullup_override_en, pullup_override_val, ext_analog_reference} <= 17'h10011;
    @(negedge clk);
    chk({pad_pullup_en, pad_oe_n}, 32'h0000_00F8);
    @(posedge clk);
    toggle_req <= 8'h80;
    // let the pulse reach the latch before the read samples it
    @(posedge clk);
    toggle_req <= 8'h00;
    bus(1'b0, LATCH_OFS, 8'h00);
    chk(rd, 32'h0000_0073);
    @(posedge clk);
    pad_in <= 8'hA5;
    @(negedge clk);
    chk({alt_raw_digital_in, pin_change_src, ext_irq_one, serial_iface_clock, timer0_capture_in},
        32'h0005_2D2E);
    @(posedge clk);
    {sleep_clamp, input_enable_override_en, input_enable_override_val} <= 17'h11614;
    @(negedge clk);
    chk({alt_raw_digital_in, ext_irq_one, timer0_capture_in}, 32'h0000_0012);
    // two-flop synchronizer needs two edges before the read samples it
    repeat (2) @(posedge clk);
    bus(1'b0, PIN_OFS, 8'h00);
    chk(rd, 32'h0000_0004);
    chk(alt_sync, 32'h0000_0004);
    stop_test;
  end
endmodule : port_pin_override_mux_tb_top
bind port_pin_override_mux port_mux_asserts u_chk (.*);
`default_nettype wire
